// file: rtl/lcd_cmd_pkg.sv
package lcd_cmd_pkg;
    localparam logic [7:0] OP_SEG_DIR = 8'hA0;
    localparam logic [7:0] OP_INVERT = 8'hA6;
    localparam logic [7:0] OP_ALL_ON = 8'hA4;
    localparam logic [7:0] OP_BIAS = 8'hA2;
    localparam logic [7:0] OP_RMW = 8'hE0;
    localparam logic [7:0] OP_END = 8'hEE;
    localparam logic [7:0] OP_SW_RESET = 8'hE2;
    localparam logic [7:0] OP_COM_DIR = 8'hC0;
    localparam logic [7:0] OP_POWER = 8'h28;
    localparam logic [7:0] OP_RATIO = 8'h20;
    localparam logic [7:0] OP_COL_HI = 8'h10;
    localparam logic [7:0] OP_COL_LO = 8'h00;
    localparam logic [7:0] OP_PAGE = 8'hB0;
    localparam logic [7:0] OP_START = 8'h40;
    localparam logic [7:0] MASK_1BIT = 8'hFE;
    localparam logic [7:0] MASK_3BIT = 8'hF8;
    localparam logic [7:0] MASK_4BIT = 8'hF0;
    localparam logic [7:0] MASK_6BIT = 8'hC0;
    localparam logic [7:0] MASK_COM = 8'hF0;
    localparam logic [7:0] COL_LAST = 8'hC7;
    localparam logic [7:0] COL_RESET = 8'h00;
    localparam logic [3:0] PAGE_RESET = 4'h0;
    localparam logic [5:0] START_RESET = 6'h00;
    localparam logic [2:0] RATIO_RESET = 3'h0;
    localparam int COM_DIR_BIT = 3;
    localparam int RAM_PAGES = 9;
    localparam int RAM_COLS = 200;
endpackage

// file: rtl/lcd_command_decoder.sv
`timescale 1ns/1ps
module lcd_command_decoder
    import lcd_cmd_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cmd_data_select,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    input wire logic serial_mode,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] scan_column,
    input wire logic [3:0] scan_page,
    input wire logic [7:0] scan_segment,
    output logic [7:0] rd_data,
    output logic [7:0] segment_column,
    output logic [7:0] pixel_bits,
    output logic seg_reversed,
    output logic invert,
    output logic all_on,
    output logic bias_low,
    output logic bias_active,
    output logic rmw_active,
    output logic com_reversed,
    output logic booster_on,
    output logic regulator_on,
    output logic follower_on,
    output logic [2:0] lcd_drive_voltage,
    output logic [7:0] column,
    output logic [3:0] page,
    output logic [5:0] start_line,
    output logic sw_reset_pending
);
    import lcd_cmd_pkg::*;

    logic [7:0] ram [RAM_PAGES][RAM_COLS];
    logic [7:0] saved_col, next_saved_col, next_column, next_rd_data;
    logic [3:0] next_page;
    logic [5:0] next_start_line;
    logic [2:0] next_ratio;
    logic next_seg, next_inv, next_all, next_bias, next_rmw, next_com;
    logic next_boost, next_reg, next_fol, next_swr;
    logic cmd_wr, data_wr, data_rd;
    logic [7:0] col_inc;

    assign cmd_wr = wr_strobe && !cmd_data_select;
    assign data_wr = wr_strobe && cmd_data_select;
    assign data_rd = rd_strobe && cmd_data_select && !serial_mode;
    // Saturating increment, page never advances here
    assign col_inc = (column == COL_LAST) ? column : column + 8'h01;

    always_comb begin
        next_column = column;
        next_page = page;
        next_start_line = start_line;
        next_ratio = lcd_drive_voltage;
        next_seg = seg_reversed;
        next_inv = invert;
        next_all = all_on;
        next_bias = bias_low;
        next_rmw = rmw_active;
        next_com = com_reversed;
        next_boost = booster_on;
        next_reg = regulator_on;
        next_fol = follower_on;
        next_saved_col = saved_col;
        next_swr = 1'b0;
        next_rd_data = rd_data;
        if (sw_reset_pending) begin
            // Applied the cycle after the byte was accepted; RAM untouched
            next_start_line = START_RESET;
            next_column = COL_RESET;
            next_page = PAGE_RESET;
            next_com = 1'b0;
            next_ratio = RATIO_RESET;
            next_rmw = 1'b0;
        end else if (cmd_wr) begin
            if ((wr_data & MASK_1BIT) == OP_SEG_DIR) begin
                next_seg = wr_data[0];
            end else if ((wr_data & MASK_1BIT) == OP_INVERT) begin
                next_inv = wr_data[0];
            end else if ((wr_data & MASK_1BIT) == OP_ALL_ON) begin
                next_all = wr_data[0];
            end else if ((wr_data & MASK_1BIT) == OP_BIAS) begin
                next_bias = wr_data[0];
            end else if (wr_data == OP_RMW) begin
                next_rmw = 1'b1;
                next_saved_col = column;
            end else if (wr_data == OP_END) begin
                next_rmw = 1'b0;
                next_column = saved_col;
            end else if (wr_data == OP_SW_RESET) begin
                next_swr = 1'b1;
            end else if ((wr_data & MASK_COM) == OP_COM_DIR) begin
                next_com = wr_data[COM_DIR_BIT];
            end else if ((wr_data & MASK_3BIT) == OP_POWER) begin
                next_boost = wr_data[2];
                next_reg = wr_data[1];
                next_fol = wr_data[0];
            end else if ((wr_data & MASK_3BIT) == OP_RATIO) begin
                next_ratio = wr_data[2:0];
            end else if ((wr_data & MASK_4BIT) == OP_COL_HI) begin
                next_column = {wr_data[3:0], column[3:0]};
            end else if ((wr_data & MASK_4BIT) == OP_COL_LO) begin
                next_column = {column[7:4], wr_data[3:0]};
            end else if ((wr_data & MASK_4BIT) == OP_PAGE) begin
                next_page = wr_data[3:0];
            end else if ((wr_data & MASK_6BIT) == OP_START) begin
                next_start_line = wr_data[5:0];
            end
        end else if (data_wr) begin
            next_column = col_inc;
        end else if (data_rd) begin
            // No read lag: outside read-modify-write the host's dummy read after a column set costs one byte
            if (page < 4'(RAM_PAGES) && column <= COL_LAST) begin
                next_rd_data = ram[page][column];
            end else begin
                next_rd_data = 8'h00;
            end
            if (!rmw_active) begin
                next_column = col_inc;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            column <= COL_RESET;
            page <= PAGE_RESET;
            start_line <= START_RESET;
            lcd_drive_voltage <= RATIO_RESET;
            seg_reversed <= 1'b0;
            invert <= 1'b0;
            all_on <= 1'b0;
            bias_low <= 1'b0;
            rmw_active <= 1'b0;
            com_reversed <= 1'b0;
            booster_on <= 1'b0;
            regulator_on <= 1'b0;
            follower_on <= 1'b0;
            saved_col <= COL_RESET;
            sw_reset_pending <= 1'b0;
            rd_data <= 8'h00;
        end else begin
            column <= next_column;
            page <= next_page;
            start_line <= next_start_line;
            lcd_drive_voltage <= next_ratio;
            seg_reversed <= next_seg;
            invert <= next_inv;
            all_on <= next_all;
            bias_low <= next_bias;
            rmw_active <= next_rmw;
            com_reversed <= next_com;
            booster_on <= next_boost;
            regulator_on <= next_reg;
            follower_on <= next_fol;
            saved_col <= next_saved_col;
            sw_reset_pending <= next_swr;
            rd_data <= next_rd_data;
        end
    end

    // RAM has no reset: contents survive both resets
    always_ff @(posedge clock) begin
        if (data_wr && !sw_reset_pending && page < 4'(RAM_PAGES) && column <= COL_LAST) begin
            ram[page][column] <= wr_data;
        end
    end

    // Display path for the scanner outside
    logic [7:0] seg_col, px;
    always_comb begin
        seg_col = seg_reversed ? (COL_LAST - scan_segment) : scan_segment;
        px = 8'h00;
        if (scan_page < 4'(RAM_PAGES) && scan_column <= COL_LAST) begin
            px = ram[scan_page][scan_column];
        end
        if (all_on) begin
            px = 8'hFF;
        end else if (invert) begin
            px = ~px;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            segment_column <= 8'h00;
            pixel_bits <= 8'h00;
            bias_active <= 1'b0;
        end else begin
            segment_column <= seg_col;
            pixel_bits <= px;
            bias_active <= follower_on;
        end
    end

    // Strobe-triggered checks skip the pending cycle, where every strobe is dropped on purpose
    a_col_saturate: assert property (@(posedge clock) disable iff (!rst_n)
        (data_wr && !sw_reset_pending && column == COL_LAST) |=> column == COL_LAST)
        else $error("column passed last");
    a_rmw_read_hold: assert property (@(posedge clock) disable iff (!rst_n)
        (data_rd && rmw_active && !sw_reset_pending) |=> $stable(column))
        else $error("column moved on rmw read");
    a_read_inc: assert property (@(posedge clock) disable iff (!rst_n)
        (data_rd && !rmw_active && !sw_reset_pending && column < COL_LAST) |=> column == $past(column) + 8'h01)
        else $error("read did not increment");
    a_end_restore: assert property (@(posedge clock) disable iff (!rst_n)
        (cmd_wr && wr_data == OP_END && !sw_reset_pending) |=> column == $past(saved_col) && !rmw_active)
        else $error("end did not restore column");
    a_swr_apply: assert property (@(posedge clock) disable iff (!rst_n)
        (cmd_wr && wr_data == OP_SW_RESET && !sw_reset_pending) |=> ##1 column == COL_RESET && !rmw_active)
        else $error("soft reset not applied");
    a_serial_noread: assert property (@(posedge clock) disable iff (!rst_n)
        (rd_strobe && serial_mode && !wr_strobe && !sw_reset_pending) |=> $stable(rd_data))
        else $error("serial read changed data");
    // A one-cycle reset clears the pixel register on the same edge as the flags, hence the reset term
    a_all_on_px: assert property (@(posedge clock) disable iff (!rst_n)
        ($past(all_on) && $past(rst_n)) |-> pixel_bits == 8'hFF)
        else $error("all on not forced");
    a_com_dir: assert property (@(posedge clock) disable iff (!rst_n)
        (cmd_wr && (wr_data & MASK_COM) == OP_COM_DIR && !sw_reset_pending) |=> com_reversed == $past(wr_data[3]))
        else $error("common direction wrong");
    a_power_bits: assert property (@(posedge clock) disable iff (!rst_n)
        (cmd_wr && (wr_data & MASK_3BIT) == OP_POWER && !sw_reset_pending)
        |=> {booster_on, regulator_on, follower_on} == $past(wr_data[2:0]))
        else $error("power bits wrong");
    a_seg_cmd: assert property (@(posedge clock) disable iff (!rst_n)
        (cmd_wr && (wr_data & MASK_1BIT) == OP_SEG_DIR && !sw_reset_pending)
        |=> seg_reversed == $past(wr_data[0]))
        else $error("segment direction wrong");
    a_invert_cmd: assert property (@(posedge clock) disable iff (!rst_n)
        (cmd_wr && (wr_data & MASK_1BIT) == OP_INVERT && !sw_reset_pending)
        |=> invert == $past(wr_data[0]))
        else $error("invert setting wrong");
    a_all_on_cmd: assert property (@(posedge clock) disable iff (!rst_n)
        (cmd_wr && (wr_data & MASK_1BIT) == OP_ALL_ON && !sw_reset_pending)
        |=> all_on == $past(wr_data[0]))
        else $error("all on setting wrong");
    a_bias_cmd: assert property (@(posedge clock) disable iff (!rst_n)
        (cmd_wr && (wr_data & MASK_1BIT) == OP_BIAS && !sw_reset_pending)
        |=> bias_low == $past(wr_data[0]))
        else $error("bias setting wrong");
    a_ratio_cmd: assert property (@(posedge clock) disable iff (!rst_n)
        (cmd_wr && (wr_data & MASK_3BIT) == OP_RATIO && !sw_reset_pending)
        |=> lcd_drive_voltage == $past(wr_data[2:0]))
        else $error("resistor ratio wrong");
    a_seg_reverse_map: assert property (@(posedge clock) disable iff (!rst_n)
        ($past(seg_reversed) && $past(rst_n)) |-> segment_column == (COL_LAST - $past(scan_segment)))
        else $error("reversed segment map wrong");
    a_seg_normal_map: assert property (@(posedge clock) disable iff (!rst_n)
        (!$past(seg_reversed) && $past(rst_n)) |-> segment_column == $past(scan_segment))
        else $error("normal segment map wrong");
    a_write_inc: assert property (@(posedge clock) disable iff (!rst_n)
        (data_wr && !sw_reset_pending && column < COL_LAST) |=> column == $past(column) + 8'h01)
        else $error("write did not increment");
    a_rmw_enter: assert property (@(posedge clock) disable iff (!rst_n)
        (cmd_wr && wr_data == OP_RMW && !sw_reset_pending)
        |=> rmw_active && saved_col == $past(column))
        else $error("mode entry did not save column");
    a_swr_wait: assert property (@(posedge clock) disable iff (!rst_n)
        (cmd_wr && wr_data == OP_SW_RESET && !sw_reset_pending)
        |=> sw_reset_pending && column == $past(column))
        else $error("soft reset acted early");
    a_data_no_cmd: assert property (@(posedge clock) disable iff (!rst_n)
        ((data_wr || data_rd) && !sw_reset_pending)
        |=> $stable({seg_reversed, invert, all_on, bias_low, com_reversed, lcd_drive_voltage, page, start_line}))
        else $error("data access changed a setting");
    a_bias_follow: assert property (@(posedge clock) disable iff (!rst_n)
        $past(rst_n) |-> bias_active == $past(follower_on))
        else $error("bias not tied to follower");
    a_page_hold: assert property (@(posedge clock) disable iff (!rst_n)
        (data_wr && !sw_reset_pending && column == COL_LAST) |=> page == $past(page))
        else $error("page moved at last column");
    a_rmw_write_inc: assert property (@(posedge clock) disable iff (!rst_n)
        (data_wr && rmw_active && !sw_reset_pending && column < COL_LAST)
        |=> column == $past(column) + 8'h01)
        else $error("rmw write did not increment");
    a_swr_settings: assert property (@(posedge clock) disable iff (!rst_n)
        (cmd_wr && wr_data == OP_SW_RESET && !sw_reset_pending)
        |=> ##1 page == PAGE_RESET && start_line == START_RESET
        && !com_reversed && lcd_drive_voltage == RATIO_RESET)
        else $error("soft reset left a setting");
    a_serial_col: assert property (@(posedge clock) disable iff (!rst_n)
        (rd_strobe && serial_mode && !wr_strobe && !sw_reset_pending) |=> $stable(column))
        else $error("serial read moved column");
    c_rmw_cycle: cover property (@(posedge clock) rmw_active ##[1:20] !rmw_active);
    c_swr: cover property (@(posedge clock) sw_reset_pending);
    c_read: cover property (@(posedge clock) data_rd ##1 data_rd);
    c_all_on_invert: cover property (@(posedge clock) all_on && invert);
    c_serial_read: cover property (@(posedge clock) rd_strobe && serial_mode);
endmodule

// file: verification/lcd_host_model.sv
`timescale 1ns/1ps
module lcd_host_model (
    input wire logic clock,
    output logic cmd_data_select,
    output logic wr_strobe,
    output logic rd_strobe,
    output logic [7:0] wr_data
);
    initial begin
        cmd_data_select = 1'b0;
        wr_strobe = 1'b0;
        rd_strobe = 1'b0;
        wr_data = 8'h00;
    end
    // Data inverted after release so a stale byte never looks valid
    task automatic put(input logic ds, input logic [7:0] b);
        @(posedge clock);
        cmd_data_select <= ds;
        wr_data <= b;
        wr_strobe <= 1'b1;
        @(posedge clock);
        wr_strobe <= 1'b0;
        wr_data <= ~b;
    endtask
    task automatic get();
        @(posedge clock);
        cmd_data_select <= 1'b1;
        rd_strobe <= 1'b1;
        @(posedge clock);
        rd_strobe <= 1'b0;
    endtask
    // High nibble first, then low nibble
    task automatic col(input logic [7:0] c);
        put(1'b0, {4'h1, c[7:4]});
        put(1'b0, {4'h0, c[3:0]});
    endtask
endmodule

// file: verification/lcd_command_decoder_part2_test.sv
`timescale 1ns/1ps
module lcd_command_decoder_part2_test;
    import lcd_cmd_pkg::*;
    logic clock, rst_n, serial_mode, cmd_data_select, wr_strobe, rd_strobe;
    logic [7:0] wr_data, scan_column, scan_segment, rd_data, segment_column, pixel_bits, column;
    logic [3:0] scan_page, page;
    logic [5:0] start_line;
    logic [2:0] lcd_drive_voltage;
    logic seg_reversed, invert, all_on, bias_low, bias_active, rmw_active, com_reversed;
    logic booster_on, regulator_on, follower_on, sw_reset_pending;
    logic [10:0] lv;
    int num_errors = 0;
    int tests_run = 0;
    localparam logic [18:0] rows [16] = '{{8'hA1, 11'h400}, {8'hA7, 11'h600}, {8'hA5, 11'h700},
        {8'hA3, 11'h780}, {8'hCF, 11'h7C0}, {8'h2F, 11'h7F8}, {8'h25, 11'h7FD}, {8'hC7, 11'h7BD},
        {8'h2A, 11'h795}, {8'hFF, 11'h795}, {8'hA0, 11'h395}, {8'hA6, 11'h195}, {8'hA4, 11'h095},
        {8'hA2, 11'h015}, {8'h28, 11'h005}, {8'h20, 11'h000}};
    assign lv = {seg_reversed, invert, all_on, bias_low, com_reversed, booster_on, regulator_on,
        follower_on, lcd_drive_voltage};
    lcd_host_model i_lcd_host_model (.clock, .cmd_data_select, .wr_strobe, .rd_strobe, .wr_data);
    lcd_command_decoder i_lcd_command_decoder (.clock, .rst_n, .cmd_data_select, .wr_strobe,
        .rd_strobe, .serial_mode, .wr_data, .scan_column, .scan_page, .scan_segment, .rd_data,
        .segment_column, .pixel_bits, .seg_reversed, .invert, .all_on, .bias_low, .bias_active,
        .rmw_active, .com_reversed, .booster_on, .regulator_on, .follower_on, .lcd_drive_voltage,
        .column, .page, .start_line, .sw_reset_pending);
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic c(input logic [7:0] b);
        i_lcd_host_model.put(1'b0, b);
        #1;
    endtask
    task automatic d(input logic [7:0] b);
        i_lcd_host_model.put(1'b1, b);
        #1;
    endtask
    task automatic rd();
        i_lcd_host_model.get();
        #1;
    endtask
    task automatic settle();
        repeat (2) @(posedge clock);
        #1;
    endtask
    task automatic summarize();
        if (num_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // Bound far above the roughly 150 cycles the tests need
    initial begin
        #40000;
        num_errors++;
        summarize();
    end
    initial begin
        rst_n = 1'b0;
        serial_mode = 1'b0;
        scan_column = 8'h05;
        scan_page = 4'h0;
        scan_segment = 8'h03;
        repeat (12) @(posedge clock);
        #1;
        chk(lv, 11'h000);
        chk({3'h0, column}, 11'h000);
        @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            c(rows[i][18:11]);
            chk(lv, rows[i][10:0]);
        end
        c(8'h29);
        settle();
        chk({10'h0, bias_active}, 11'h001);
        c(8'hA1);
        i_lcd_host_model.col(8'h05);
        d(8'hAA);
        d(8'h55);
        chk({3'h0, column}, 11'h007);
        i_lcd_host_model.col(8'h04);
        rd();
        rd();
        chk({3'h0, rd_data}, 11'h0AA);
        chk({3'h0, column}, 11'h006);
        rd();
        chk({3'h0, rd_data}, 11'h055);
        settle();
        chk({3'h0, segment_column}, 11'd196);
        chk({3'h0, pixel_bits}, 11'h0AA);
        c(8'hA7);
        settle();
        chk({3'h0, pixel_bits}, 11'h055);
        c(8'hA5);
        settle();
        chk({3'h0, pixel_bits}, 11'h0FF);
        c(8'hA4);
        c(8'hA6);
        c(8'hA0);
        settle();
        chk({3'h0, segment_column}, 11'd3);
        // Read-modify-write round trip, no column set inside it
        i_lcd_host_model.col(8'h05);
        c(OP_RMW);
        rd();
        rd();
        chk({3'h0, rd_data}, 11'h0AA);
        chk({3'h0, column}, 11'h005);
        d(8'h3C);
        chk({3'h0, column}, 11'h006);
        c(OP_END);
        chk({2'h0, rmw_active, column}, 11'h005);
        i_lcd_host_model.col(8'h05);
        @(posedge clock);
        serial_mode <= 1'b1;
        rd();
        chk({3'h0, column}, 11'h005);
        chk({3'h0, rd_data}, 11'h0AA);
        @(posedge clock);
        serial_mode <= 1'b0;
        i_lcd_host_model.col(8'hC6);
        d(8'h01);
        d(8'h02);
        d(8'h03);
        chk({page, 3'h0, column[3:0]}, 11'h007);
        chk({3'h0, column}, 11'h0C7);
        @(posedge clock);
        scan_column <= 8'hC7;
        scan_segment <= 8'hC7;
        settle();
        chk({3'h0, pixel_bits}, 11'h003);
        chk({3'h0, segment_column}, 11'h0C7);
        @(posedge clock);
        scan_page <= 4'h9;
        settle();
        chk({3'h0, pixel_bits}, 11'h000);
        c(8'hB3);
        c(8'h4A);
        c(8'h23);
        c(8'hC8);
        c(8'hA1);
        c(OP_RMW);
        chk({page, start_line, com_reversed}, 11'h195);
        c(OP_SW_RESET);
        chk({10'h0, sw_reset_pending}, 11'h001);
        settle();
        chk({page, start_line, com_reversed}, 11'h000);
        chk({column, lcd_drive_voltage}, 11'h000);
        chk({9'h0, rmw_active, seg_reversed}, 11'h001);
        // Mid-run hardware reset: settings clear, RAM survives
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        chk(lv, 11'h000);
        @(posedge clock);
        rst_n <= 1'b1;
        i_lcd_host_model.col(8'h04);
        rd();
        rd();
        chk({3'h0, rd_data}, 11'h03C);
        summarize();
    end
endmodule
